// ### logic/io_expander_pkg.sv
// Package with register map, field positions, reset values and timing for the I/O expander.
package io_expander_pkg;
    localparam logic [6:0] BUS_ADDR = 7'h48;
    localparam logic [7:0] BUS_ADDR_BYTE = 8'h90;
    localparam logic [7:0] REG_DISPLAY_CONTROL = 8'h00;
    localparam logic [7:0] REG_SERIAL_BRIDGE_CONTROL = 8'h01;
    localparam logic [7:0] REG_SENSOR_CONTROL = 8'h02;
    localparam logic [7:0] REG_LAMP_CONTROL = 8'h03;
    localparam int DISP_OWNER_BIT = 0;
    localparam int DISP_POLARITY_BIT = 1;
    localparam int DISP_AUTO_BIT = 2;
    localparam int ENABLE_BIT = 0;
    localparam int LAMP_A_BIT = 0;
    localparam int LAMP_B_BIT = 1;
    localparam int LAMP_OVERRIDE_BIT = 7;
    localparam logic [7:0] DISPLAY_CONTROL_RESET = 8'h00;
    localparam logic [7:0] SERIAL_BRIDGE_CONTROL_RESET = 8'h01;
    localparam logic [7:0] SENSOR_CONTROL_RESET = 8'h00;
    localparam logic [7:0] LAMP_CONTROL_RESET = 8'h00;
    localparam int CLK_HZ = 40_000_000;
    localparam int TOGGLE_HZ = 60;
    localparam int TOGGLE_CYCLES = CLK_HZ / TOGGLE_HZ;
    localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    typedef struct packed {
        logic scl;
        logic sda;
    } i2c_line_type;

    typedef enum logic [8:0] {
        ST_IDLE      = 9'b0_0000_0001,
        ST_ADDR      = 9'b0_0000_0010,
        ST_ADDR_ACK  = 9'b0_0000_0100,
        ST_PTR       = 9'b0_0000_1000,
        ST_PTR_ACK   = 9'b0_0001_0000,
        ST_WDATA     = 9'b0_0010_0000,
        ST_WDATA_ACK = 9'b0_0100_0000,
        ST_READ      = 9'b0_1000_0000,
        ST_READ_ACK  = 9'b1_0000_0000
    } i2c_state_type;
endpackage

// ### logic/io_expander_ctrl.sv
// I2C-reached register bank driving lamps, display, sensor and serial-bridge enables.
//
// Summary of operation
// - Without override, lamps follow their button lines.
// - Low button a lights lamp a, b lights b.
// - Override bit 7 shows lamp register bits 0,1.
// - Override set: lamps ignore button lines.
// - Display owner follows display control bit 0.
// - Display control bit 1 sets polarity output.
// - Auto bit toggles polarity at 60 Hz.
// - Owner low gives display to board controller.
// - Sensor enable follows sensor control bit 0.
// - Sensor isolated unless enable is high.
// - Bridge enable follows bridge control bit 0.
// - Bridge enable is active after reset.
// - UART passes only while bridge enabled.
// - Write: address+write, register byte, data byte.
// - Read: set pointer by write, then start+read.
`timescale 1ns/1ps
`default_nettype none
module io_expander_ctrl #(
    parameter int TOGGLE_CYCLES = io_expander_pkg::TOGGLE_CYCLES
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_i2c_scl,
    input wire logic i_i2c_sda,
    output logic o_i2c_sda_out,
    output logic o_i2c_sda_oe,
    input wire logic i_expander_wake_n,
    input wire logic i_button_line_a_n,
    input wire logic i_button_line_b_n,
    output logic o_user_lamp_a,
    output logic o_user_lamp_b,
    output logic o_display_owner,
    output logic o_display_polarity_invert,
    output logic o_sensor_enable,
    output logic o_serial_bridge_enable,
    input wire logic i_uart_target_tx,
    output logic o_uart_to_controller,
    input wire logic i_uart_controller_tx,
    output logic o_uart_to_target
);
    localparam int NIN = 7;

    // Every pin input passes three flops; a change counts once stages two and three agree.
    logic [NIN-1:0] sync1_ff;
    logic [NIN-1:0] sync2_ff;
    logic [NIN-1:0] sync3_ff;
    logic [NIN-1:0] filt_ff;
    logic [NIN-1:0] pins;
    assign pins = {i_uart_controller_tx, i_uart_target_tx, i_button_line_b_n,
                   i_button_line_a_n, i_expander_wake_n, i_i2c_sda, i_i2c_scl};

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            sync1_ff <= 7'h7F;
            sync2_ff <= 7'h7F;
            sync3_ff <= 7'h7F;
            filt_ff <= 7'h7F;
        end else begin
            sync1_ff <= pins;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            for (int k = 0; k < NIN; k++) begin
                if (sync2_ff[k] == sync3_ff[k]) begin
                    filt_ff[k] <= sync3_ff[k];
                end
            end
        end
    end

    io_expander_pkg::i2c_line_type line;
    io_expander_pkg::i2c_line_type line_prev_ff;
    assign line.scl = filt_ff[0];
    assign line.sda = filt_ff[1];
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            line_prev_ff <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            line_prev_ff <= line;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic awake;
    assign scl_rise = line.scl && !line_prev_ff.scl;
    assign scl_fall = !line.scl && line_prev_ff.scl;
    assign start_seen = line.scl && line_prev_ff.scl && line_prev_ff.sda && !line.sda;
    assign stop_seen = line.scl && line_prev_ff.scl && !line_prev_ff.sda && line.sda;
    assign awake = !filt_ff[2];

    logic [7:0] display_control_ff;
    logic [7:0] serial_bridge_control_ff;
    logic [7:0] sensor_control_ff;
    logic [7:0] lamp_control_ff;
    logic polarity_ff;
    logic [7:0] pointer_ff;
    logic [7:0] shift_ff;
    logic [3:0] count_ff;
    logic nack_ff;
    logic write_stb;
    logic [7:0] read_data;
    io_expander_pkg::i2c_state_type state_ff;

    always_comb begin
        unique case (pointer_ff)
            io_expander_pkg::REG_DISPLAY_CONTROL:
                read_data = {display_control_ff[7:2], polarity_ff, display_control_ff[0]};
            io_expander_pkg::REG_SERIAL_BRIDGE_CONTROL: read_data = serial_bridge_control_ff;
            io_expander_pkg::REG_SENSOR_CONTROL: read_data = sensor_control_ff;
            io_expander_pkg::REG_LAMP_CONTROL: read_data = lamp_control_ff;
            default: read_data = 8'h00;
        endcase
    end

    // The data byte is committed on the falling edge that ends its eighth bit.
    assign write_stb = (state_ff == io_expander_pkg::ST_WDATA) && scl_fall &&
                       (count_ff == io_expander_pkg::BYTE_BITS);

    // I2C target sequencer; sleeps and releases the data line while wake is high.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_ff <= io_expander_pkg::ST_IDLE;
            shift_ff <= 8'h00;
            count_ff <= 4'h0;
            pointer_ff <= 8'h00;
            nack_ff <= 1'b0;
            o_i2c_sda_oe <= 1'b0;
        end else if (!awake) begin
            state_ff <= io_expander_pkg::ST_IDLE;
            count_ff <= 4'h0;
            o_i2c_sda_oe <= 1'b0;
        end else if (start_seen) begin
            state_ff <= io_expander_pkg::ST_ADDR;
            count_ff <= 4'h0;
            o_i2c_sda_oe <= 1'b0;
        end else if (stop_seen) begin
            state_ff <= io_expander_pkg::ST_IDLE;
            o_i2c_sda_oe <= 1'b0;
        end else begin
            unique case (state_ff)
                io_expander_pkg::ST_IDLE: begin
                    o_i2c_sda_oe <= 1'b0;
                end
                io_expander_pkg::ST_ADDR, io_expander_pkg::ST_PTR, io_expander_pkg::ST_WDATA: begin
                    if (scl_rise) begin
                        shift_ff <= {shift_ff[6:0], line.sda};
                        count_ff <= count_ff + 4'h1;
                    end else if (scl_fall && count_ff == io_expander_pkg::BYTE_BITS) begin
                        count_ff <= 4'h0;
                        if (state_ff == io_expander_pkg::ST_ADDR) begin
                            if (shift_ff[7:1] == io_expander_pkg::BUS_ADDR) begin
                                state_ff <= io_expander_pkg::ST_ADDR_ACK;
                                o_i2c_sda_oe <= 1'b1;
                            end else begin
                                state_ff <= io_expander_pkg::ST_IDLE;
                            end
                        end else if (state_ff == io_expander_pkg::ST_PTR) begin
                            pointer_ff <= shift_ff;
                            state_ff <= io_expander_pkg::ST_PTR_ACK;
                            o_i2c_sda_oe <= 1'b1;
                        end else begin
                            state_ff <= io_expander_pkg::ST_WDATA_ACK;
                            o_i2c_sda_oe <= 1'b1;
                        end
                    end
                end
                io_expander_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (shift_ff[0]) begin
                            state_ff <= io_expander_pkg::ST_READ;
                            shift_ff <= read_data;
                            o_i2c_sda_oe <= !read_data[7];
                        end else begin
                            state_ff <= io_expander_pkg::ST_PTR;
                            o_i2c_sda_oe <= 1'b0;
                        end
                    end
                end
                io_expander_pkg::ST_PTR_ACK, io_expander_pkg::ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        state_ff <= io_expander_pkg::ST_WDATA;
                        o_i2c_sda_oe <= 1'b0;
                    end
                end
                io_expander_pkg::ST_READ: begin
                    if (scl_fall) begin
                        if (count_ff == io_expander_pkg::BYTE_LAST_BIT) begin
                            state_ff <= io_expander_pkg::ST_READ_ACK;
                            count_ff <= 4'h0;
                            o_i2c_sda_oe <= 1'b0;
                        end else begin
                            shift_ff <= {shift_ff[6:0], 1'b0};
                            count_ff <= count_ff + 4'h1;
                            o_i2c_sda_oe <= !shift_ff[6];
                        end
                    end
                end
                io_expander_pkg::ST_READ_ACK: begin
                    if (scl_rise) begin
                        nack_ff <= line.sda;
                    end else if (scl_fall) begin
                        if (nack_ff) begin
                            state_ff <= io_expander_pkg::ST_IDLE;
                        end else begin
                            state_ff <= io_expander_pkg::ST_READ;
                            shift_ff <= read_data;
                            o_i2c_sda_oe <= !read_data[7];
                        end
                    end
                end
                default: begin
                    state_ff <= io_expander_pkg::ST_IDLE;
                    o_i2c_sda_oe <= 1'b0;
                end
            endcase
        end
    end

    assign o_i2c_sda_out = 1'b0;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            display_control_ff <= io_expander_pkg::DISPLAY_CONTROL_RESET;
            serial_bridge_control_ff <= io_expander_pkg::SERIAL_BRIDGE_CONTROL_RESET;
            sensor_control_ff <= io_expander_pkg::SENSOR_CONTROL_RESET;
            lamp_control_ff <= io_expander_pkg::LAMP_CONTROL_RESET;
        end else if (write_stb) begin
            unique case (pointer_ff)
                io_expander_pkg::REG_DISPLAY_CONTROL: display_control_ff <= shift_ff;
                io_expander_pkg::REG_SERIAL_BRIDGE_CONTROL: serial_bridge_control_ff <= shift_ff;
                io_expander_pkg::REG_SENSOR_CONTROL: sensor_control_ff <= shift_ff;
                io_expander_pkg::REG_LAMP_CONTROL: lamp_control_ff <= shift_ff;
                default: ;
            endcase
        end
    end

    // Polarity output: a write sets it; otherwise the auto mode toggles it every 1/60 s.
    logic [23:0] toggle_cnt_ff;
    logic toggle_tick;
    assign toggle_tick = (toggle_cnt_ff == 24'(TOGGLE_CYCLES - 1));
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            toggle_cnt_ff <= 24'h00_0000;
        end else if (!display_control_ff[io_expander_pkg::DISP_AUTO_BIT] || toggle_tick) begin
            toggle_cnt_ff <= 24'h00_0000;
        end else begin
            toggle_cnt_ff <= toggle_cnt_ff + 24'h00_0001;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            polarity_ff <= 1'b0;
        end else if (write_stb && pointer_ff == io_expander_pkg::REG_DISPLAY_CONTROL) begin
            polarity_ff <= shift_ff[io_expander_pkg::DISP_POLARITY_BIT];
        end else if (display_control_ff[io_expander_pkg::DISP_AUTO_BIT] && toggle_tick) begin
            polarity_ff <= !polarity_ff;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_user_lamp_a <= 1'b0;
            o_user_lamp_b <= 1'b0;
            o_display_owner <= 1'b0;
            o_display_polarity_invert <= 1'b0;
            o_sensor_enable <= 1'b0;
            o_serial_bridge_enable <= 1'b0;
            o_uart_to_controller <= 1'b1;
            o_uart_to_target <= 1'b1;
        end else begin
            if (lamp_control_ff[io_expander_pkg::LAMP_OVERRIDE_BIT]) begin
                o_user_lamp_a <= lamp_control_ff[io_expander_pkg::LAMP_A_BIT];
                o_user_lamp_b <= lamp_control_ff[io_expander_pkg::LAMP_B_BIT];
            end else begin
                o_user_lamp_a <= !filt_ff[3];
                o_user_lamp_b <= !filt_ff[4];
            end
            o_display_owner <= display_control_ff[io_expander_pkg::DISP_OWNER_BIT];
            o_display_polarity_invert <= polarity_ff;
            o_sensor_enable <= sensor_control_ff[io_expander_pkg::ENABLE_BIT];
            o_serial_bridge_enable <= serial_bridge_control_ff[io_expander_pkg::ENABLE_BIT];
            // Disabled bridge holds both directions at UART idle.
            o_uart_to_controller <= filt_ff[5] ||
                !serial_bridge_control_ff[io_expander_pkg::ENABLE_BIT];
            o_uart_to_target <= filt_ff[6] ||
                !serial_bridge_control_ff[io_expander_pkg::ENABLE_BIT];
        end
    end
endmodule
`default_nettype wire

// ### testbench/io_expander_ctrl_sva.sv
// Port-level checker for the I/O expander register bank.
`timescale 1ns/1ps
`default_nettype none
module io_expander_ctrl_sva #(
    parameter int TOGGLE_CYCLES = 20
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_i2c_scl,
    input wire logic o_i2c_sda_out,
    input wire logic o_i2c_sda_oe,
    input wire logic i_expander_wake_n,
    input wire logic i_button_line_a_n,
    input wire logic o_user_lamp_a,
    input wire logic o_display_owner,
    input wire logic o_display_polarity_invert,
    input wire logic o_sensor_enable,
    input wire logic o_serial_bridge_enable,
    input wire logic i_uart_target_tx,
    input wire logic o_uart_to_controller
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    logic prev_pol_ff;
    logic calm_ff;
    int cnt_ff;
    // Counts cycles between polarity changes that saw no bus access in between.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            prev_pol_ff <= 1'b0;
            calm_ff <= 1'b0;
            cnt_ff <= 0;
        end else begin
            prev_pol_ff <= o_display_polarity_invert;
            calm_ff <= (o_display_polarity_invert != prev_pol_ff) ? i_expander_wake_n
                : (calm_ff & i_expander_wake_n);
            cnt_ff <= (o_display_polarity_invert != prev_pol_ff) ? 1 : cnt_ff + 1;
        end
    end
    sequence asleep;
        i_expander_wake_n;
    endsequence
    sequence quiet_a;
        i_expander_wake_n && $stable(i_button_line_a_n);
    endsequence
    sequence tx_low;
        o_serial_bridge_enable && !i_uart_target_tx;
    endsequence
    reset_values_a: assert property ($fell(i_rst) |-> !o_display_owner && !o_sensor_enable
        && !o_display_polarity_invert ##[1:2] o_serial_bridge_enable) else $error("bad reset values");
    sda_value_a: assert property (!o_i2c_sda_out) else $error("sda driven high");
    sda_sleep_a: assert property (asleep [*6] |-> !o_i2c_sda_oe) else $error("sda pulled asleep");
    ack_timing_a: assert property ($rose(o_i2c_sda_oe) |-> !i_i2c_scl)
        else $error("sda changed while scl high");
    lamp_hold_a: assert property (quiet_a [*8] |=> $stable(o_user_lamp_a))
        else $error("lamp moved without cause");
    ctrl_hold_a: assert property (asleep [*8] |=> $stable(o_display_owner) &&
        $stable(o_sensor_enable) && $stable(o_serial_bridge_enable)) else $error("control moved");
    auto_period_a: assert property ((o_display_polarity_invert != prev_pol_ff) && calm_ff
        |-> cnt_ff == TOGGLE_CYCLES) else $error("polarity toggle period wrong");
    uart_pass_a: assert property (tx_low [*8] |-> !o_uart_to_controller)
        else $error("uart data not passed");
    bridge_gate_a: assert property (!o_serial_bridge_enable [*8] |-> o_uart_to_controller)
        else $error("uart passed while disabled");
endmodule
bind io_expander_ctrl io_expander_ctrl_sva #(.TOGGLE_CYCLES(TOGGLE_CYCLES)) io_expander_ctrl_sva_inst (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_i2c_scl(i_i2c_scl), .o_i2c_sda_out(o_i2c_sda_out),
    .o_i2c_sda_oe(o_i2c_sda_oe), .i_expander_wake_n(i_expander_wake_n),
    .i_button_line_a_n(i_button_line_a_n), .o_user_lamp_a(o_user_lamp_a),
    .o_display_owner(o_display_owner), .o_display_polarity_invert(o_display_polarity_invert),
    .o_sensor_enable(o_sensor_enable), .o_serial_bridge_enable(o_serial_bridge_enable),
    .i_uart_target_tx(i_uart_target_tx), .o_uart_to_controller(o_uart_to_controller));
`default_nettype wire

// ### testbench/io_expander_host.sv
// Host controller model that reaches the expander registers over I2C.
`timescale 1ns/1ps
`default_nettype none
module io_expander_host (
    input wire logic i_clk_sys,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low,
    output logic o_wake_n
);
    logic got;
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
        o_wake_n = 1'b1;
    end
    // Lines are moved one at a time so no false start or stop appears.
    task automatic drv(input logic sda_v, input logic scl_v, input int n);
        o_sda_low = !sda_v;
        o_scl = scl_v;
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask
    task automatic bit_x(input logic b);
        drv(b, 1'b0, 6);
        drv(b, 1'b1, 12);
        got = i_sda;
        drv(b, 1'b0, 6);
    endtask
    task automatic start();
        drv(1'b1, 1'b0, 6);
        drv(1'b1, 1'b1, 12);
        drv(1'b0, 1'b1, 12);
        drv(1'b0, 1'b0, 6);
    endtask
    task automatic byte_x(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_x(tx[i]);
            rx[i] = got;
        end
        bit_x(1'b1);
        ack = !got;
    endtask
    task automatic open(input logic [7:0] dev, input logic [7:0] r, output logic ack);
        logic [7:0] rx;
        logic a0;
        o_wake_n = 1'b0;
        drv(1'b1, 1'b1, 6);
        start();
        byte_x(dev, rx, a0);
        byte_x(r, rx, ack);
        ack = ack & a0;
    endtask
    task automatic close();
        drv(1'b0, 1'b0, 6);
        drv(1'b0, 1'b1, 12);
        drv(1'b1, 1'b1, 10);
        o_wake_n = 1'b1;
        drv(1'b1, 1'b1, 10);
    endtask
    task automatic write_reg(input logic [7:0] dev, input logic [7:0] r, input logic [7:0] d,
        output logic ack);
        logic [7:0] rx;
        logic a;
        open(dev, r, ack);
        byte_x(d, rx, a);
        close();
        ack = ack & a;
    endtask
    task automatic read_reg(input logic [7:0] r, output logic [7:0] d, output logic ack);
        logic a;
        open(io_expander_pkg::BUS_ADDR_BYTE, r, ack);
        start();
        byte_x(io_expander_pkg::BUS_ADDR_BYTE | 8'h01, d, a);
        ack = ack & a;
        byte_x(8'hff, d, a);
        close();
    endtask
endmodule
`default_nettype wire

// ### testbench/io_expander_ctrl_bench.sv
// Self-checking bench for the I/O expander register bank.
`timescale 1ns/1ps
`default_nettype none
module io_expander_ctrl_bench;
    localparam int TC = 20;
    logic clk;
    logic rst;
    logic scl;
    logic sda;
    logic host_low;
    logic sda_oe;
    logic wake_n;
    logic ba_n;
    logic bb_n;
    logic utx;
    logic ctx;
    logic ack;
    wire logic [7:0] outs;
    int n_errors = 0;
    int num_checks = 0;
    int n;
    assign sda = (host_low || sda_oe) ? 1'b0 : 1'b1;
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    io_expander_ctrl #(.TOGGLE_CYCLES(TC)) io_expander_ctrl_inst (
        .i_clk_sys(clk), .i_rst(rst), .i_i2c_scl(scl), .i_i2c_sda(sda), .o_i2c_sda_out(),
        .o_i2c_sda_oe(sda_oe), .i_expander_wake_n(wake_n), .i_button_line_a_n(ba_n),
        .i_button_line_b_n(bb_n), .o_user_lamp_a(outs[0]), .o_user_lamp_b(outs[1]),
        .o_display_owner(outs[2]), .o_display_polarity_invert(outs[3]),
        .o_sensor_enable(outs[4]), .o_serial_bridge_enable(outs[5]),
        .i_uart_target_tx(utx), .o_uart_to_controller(outs[6]),
        .i_uart_controller_tx(ctx), .o_uart_to_target(outs[7]));
    io_expander_host io_expander_host_inst (
        .i_clk_sys(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(host_low), .o_wake_n(wake_n));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wt(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] r, input logic [7:0] d);
        io_expander_host_inst.write_reg(io_expander_pkg::BUS_ADDR_BYTE, r, d, ack);
        chk("write ack", 8'h01, {7'h00, ack});
    endtask
    task automatic rd(input logic [7:0] r, input logic [7:0] exp);
        logic [7:0] d;
        io_expander_host_inst.read_reg(r, d, ack);
        chk("read ack", 8'h01, {7'h00, ack});
        chk("read data", exp, d);
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        {bb_n, ba_n, utx, ctx} = 4'hf;
        wt(20);
        rst = 1'b0;
        wt(10);
        chk("reset outputs", 8'he0, outs);
        for (int i = 0; i < 5; i++) rd(i[7:0], {7'h00, i == 1});
        for (int i = 0; i < 4; i++) begin
            {bb_n, ba_n} = i[1:0];
            wt(10);
            chk("lamps follow buttons", 8'he0 | {6'h00, ~i[1:0]}, outs);
        end
        for (int v = 1; v < 3; v++) begin
            wr(8'h03, 8'h80 | v[7:0]);
            rd(8'h03, 8'h80 | v[7:0]);
            for (int i = 0; i < 4; i++) begin
                {bb_n, ba_n} = i[1:0];
                wt(10);
                chk("lamp override", 8'he0 | v[7:0], outs);
            end
        end
        wr(8'h03, 8'h03);
        chk("override off", 8'he0, outs);
        for (int v = 0; v < 4; v++) begin
            wr(8'h00, v[7:0]);
            chk("display outputs", 8'he0 | {4'h0, v[1:0], 2'b00}, outs);
            rd(8'h00, v[7:0]);
        end
        wr(8'h00, 8'h04);
        for (int t = 0; t < 2; t++) begin
            n = 0;
            ack = outs[3];
            while (outs[3] === ack && n < 4 * TC) begin
                wt(1);
                n++;
            end
        end
        chk("toggle period", TC[7:0], n[7:0]);
        wr(8'h00, 8'h00);
        chk("auto off", 8'he0, outs);
        wr(8'h02, 8'h01);
        chk("sensor on", 8'hf0, outs);
        rd(8'h02, 8'h01);
        io_expander_host_inst.write_reg(8'h92, 8'h02, 8'h00, ack);
        chk("foreign address ack", 8'h00, {7'h00, ack});
        chk("foreign write", 8'hf0, outs);
        wr(8'h02, 8'h00);
        chk("sensor off", 8'he0, outs);
        {utx, ctx} = 2'b00;
        wt(10);
        chk("uart pass", 8'h20, outs);
        wr(8'h01, 8'h00);
        chk("uart blocked", 8'hc0, outs);
        rd(8'h01, 8'h00);
        wr(8'h01, 8'h01);
        chk("uart pass again", 8'h20, outs);
        conclude();
    end
endmodule
`default_nettype wire
